// >>> core/eiv_map.svh
// Purpose: Register map, field positions and vector numbers of the
//          external interrupt and vector logic.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Definitions only, no logic.
`ifndef EIV_MAP_SVH
`define EIV_MAP_SVH

// ======================================================================
// Register offsets
`define EIV_OFS_SENSE      6'h35
`define EIV_OFS_MASK       6'h3B
`define EIV_OFS_FLAG       6'h3A
`define EIV_OFS_TMASK_LO   6'h12
`define EIV_OFS_TMASK_HI   6'h13
`define EIV_OFS_STATUS     6'h14

// ======================================================================
// Field positions
`define EIV_SENSE_HI       1
`define EIV_SENSE_LO       0
`define EIV_MASK_EXT       6
`define EIV_MASK_GRP1      5
`define EIV_MASK_GRP0      4
`define EIV_FLAG_EXT       6
`define EIV_FLAG_GRP1      1
`define EIV_FLAG_GRP0      0
`define EIV_STAT_PIN       7
`define EIV_STAT_REQ       5
`define EIV_STAT_VEC_HI    4
`define EIV_TMASK_HI_W     4

// ======================================================================
// Reset values
`define EIV_RST_BYTE       8'h00
`define EIV_RST_SENSE      2'h0
`define EIV_RST_NIBBLE     4'h0
`define EIV_RST_VEC        5'h00

// ======================================================================
// Vector numbers (program word addresses) and source counts
`define EIV_VEC_RESET      5'h00
`define EIV_VEC_EXT        5'h01
`define EIV_VEC_GRP0       5'h02
`define EIV_VEC_GRP1       5'h03
`define EIV_VEC_FIRST_PER  5'h04
`define EIV_VEC_LAST_PER   5'h1D
`define EIV_NUM_PER        26
`define EIV_NUM_VEC        30
`define EIV_NUM_PINS       12
`define EIV_GRP0_HI        7
`define EIV_GRP1_LO        8

`endif

// >>> core/eiv_pkg.sv
// Purpose: Types shared by the external interrupt and vector logic.
// Assumes: Constants come from eiv_map.svh.
// Notes:   Sense modes are listed in field-code order.
package eiv_pkg;

  // ====================================================================
  // Sense mode of the external pin, in field order 00, 01, 10, 11.
  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } eiv_sense_type;

  // ====================================================================
  // One register bus request.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eiv_bus_type;

  // ====================================================================
  // Request presented to the processor core.
  typedef struct packed {
    logic       req;
    logic [4:0] vector;
  } eiv_irq_type;

endpackage

// >>> core/eiv_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

module eiv_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // Asynchronous inputs and their filtered value.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Shift chain; a bit changes once the second and third stages agree.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      level_out <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// >>> core/eiv_top.sv
// Purpose: External pin and pin toggle interrupt detection, flag and mask
//          registers, and vector selection toward the processor core.
// Assumes: One 25 MHz clock; the I/O clock of the part is modelled by the
//          io_clk_run_in level, the sleep-time detectors keep running.
// Notes:   Register reads answer one cycle after the read strobe.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "eiv_map.svh"

module eiv_top
  import eiv_pkg::*;
(
  // Clock and reset.
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  // Register port.
  input  wire logic [5:0]               reg_addr_in,
  input  wire logic [7:0]               reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [7:0]               reg_rdata_out,
  // Pad inputs, read whatever the pin direction.
  input  wire logic                     ext_irq_pin_in,
  input  wire logic [`EIV_NUM_PINS-1:0] pin_toggle_input_in,
  // Core state and other interrupt sources.
  input  wire logic                     global_irq_enable_in,
  input  wire logic                     io_clk_run_in,
  input  wire logic [`EIV_NUM_PER-1:0]  periph_irq_in,
  // Request, acknowledge and wake toward the core.
  output logic                          irq_req_out,
  output logic      [4:0]               irq_vector_out,
  input  wire logic                     irq_ack_in,
  output logic      [4:0]               reset_vector_out,
  output logic                          wake_out
);

  // ======================================================================
  // Declarations
  eiv_bus_type                bus;
  eiv_irq_type                irq_d;
  eiv_sense_type              sense;
  logic [1:0]                 sense_q;
  logic                       ext_en_q;
  logic                       grp1_en_q;
  logic                       grp0_en_q;
  logic                       ext_flag_q;
  logic                       grp1_flag_q;
  logic                       grp0_flag_q;
  logic [7:0]                 tmask_lo_q;
  logic [`EIV_TMASK_HI_W-1:0] tmask_hi_q;
  logic [`EIV_NUM_PINS:0]     pins_sync;
  logic                       ext_pin;
  logic [`EIV_NUM_PINS-1:0]   tog_pins;
  logic                       ext_prev_q;
  logic [`EIV_NUM_PINS-1:0]   tog_prev_q;
  logic                       ext_event;
  logic [`EIV_NUM_PINS-1:0]   tog_changed;
  logic                       grp0_event;
  logic                       grp1_event;
  logic                       level_active;
  logic [`EIV_NUM_VEC-1:0]    pending;
  logic                       ack_ext;
  logic                       ack_grp0;
  logic                       ack_grp1;
  logic                       w1c_ext;
  logic                       w1c_grp0;
  logic                       w1c_grp1;
  logic                       wr_flag;

  // ======================================================================
  // Register port request gathered into one carrier.
  assign bus.addr  = reg_addr_in;
  assign bus.wdata = reg_wdata_in;
  assign bus.wr    = reg_wr_in;
  assign bus.rd    = reg_rd_in;

  // Decode of the sense field into the mode enumeration.
  assign sense = eiv_sense_type'(sense_q);

  // ======================================================================
  // Pad synchronisers
  // The external pin and the twelve toggle inputs share one synchroniser
  // block; the pad value is taken whatever the pin direction, so software
  // driving the pin as an output still raises the request.
  eiv_sync #(
    .WIDTH (`EIV_NUM_PINS + 1)
  ) u_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .async_in  ({ext_irq_pin_in, pin_toggle_input_in}),
    .level_out (pins_sync)
  );

  assign ext_pin  = pins_sync[`EIV_NUM_PINS];
  assign tog_pins = pins_sync[`EIV_NUM_PINS-1:0];

  // ======================================================================
  // External pin edge detection
  // The previous sample only advances while the I/O clock runs, so an
  // edge during sleep is seen once the clock restarts if the pin keeps its new level.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_prev_q <= 1'b0;
    end else if (io_clk_run_in) begin
      ext_prev_q <= ext_pin;
    end
  end

  // Edge classification by the selected sense mode.
  always_comb begin
    ext_event = 1'b0;
    if (io_clk_run_in) begin
      case (sense)
        SENSE_ANY:  ext_event = ext_pin ^ ext_prev_q;
        SENSE_FALL: ext_event = ext_prev_q & ~ext_pin;
        SENSE_RISE: ext_event = ~ext_prev_q & ext_pin;
        SENSE_LOW:  ext_event = 1'b0;
        default:    ext_event = 1'b0;
      endcase
    end
  end

  // Low level request is a plain level, taken without the I/O clock; it
  // vanishes with the level, so a level gone before wake-up gives nothing.
  assign level_active = (sense == SENSE_LOW) & ~ext_pin;

  // ======================================================================
  // Pin toggle detection
  // Toggle detection runs whether or not the I/O clock is running, since
  // it must be able to wake the part.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tog_prev_q <= '0;
    end else begin
      tog_prev_q <= tog_pins;
    end
  end

  // Only pins whose own mask bit is set can report a change.
  assign tog_changed = (tog_pins ^ tog_prev_q) &
                       {tmask_hi_q, tmask_lo_q};
  assign grp0_event  = |tog_changed[`EIV_GRP0_HI:0];
  assign grp1_event  = |tog_changed[`EIV_NUM_PINS-1:`EIV_GRP1_LO];

  // ======================================================================
  // Flag clear sources
  // Acknowledge of the presented vector clears its flag; a write of one
  // to a flag bit clears it too.
  assign wr_flag  = bus.wr & (bus.addr == `EIV_OFS_FLAG);
  assign ack_ext  = irq_ack_in & irq_req_out &
                    (irq_vector_out == `EIV_VEC_EXT);
  assign ack_grp0 = irq_ack_in & irq_req_out &
                    (irq_vector_out == `EIV_VEC_GRP0);
  assign ack_grp1 = irq_ack_in & irq_req_out &
                    (irq_vector_out == `EIV_VEC_GRP1);
  assign w1c_ext  = wr_flag & bus.wdata[`EIV_FLAG_EXT];
  assign w1c_grp0 = wr_flag & bus.wdata[`EIV_FLAG_GRP0];
  assign w1c_grp1 = wr_flag & bus.wdata[`EIV_FLAG_GRP1];

  // ======================================================================
  // External interrupt flag
  // A new edge in the same cycle as a clear wins; in level mode the flag
  // is held clear throughout.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_flag_q <= 1'b0;
    end else if (sense == SENSE_LOW) begin
      ext_flag_q <= 1'b0;
    end else if (ext_event) begin
      ext_flag_q <= 1'b1;
    end else if (ack_ext || w1c_ext) begin
      ext_flag_q <= 1'b0;
    end
  end

  // ======================================================================
  // Toggle group flags
  // Set on any masked change of the group, set winning over clear.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      grp0_flag_q <= 1'b0;
    end else if (grp0_event) begin
      grp0_flag_q <= 1'b1;
    end else if (ack_grp0 || w1c_grp0) begin
      grp0_flag_q <= 1'b0;
    end
  end

  // Upper group flag.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      grp1_flag_q <= 1'b0;
    end else if (grp1_event) begin
      grp1_flag_q <= 1'b1;
    end else if (ack_grp1 || w1c_grp1) begin
      grp1_flag_q <= 1'b0;
    end
  end

  // ======================================================================
  // Control registers
  // Sense field, source enables and pin masks; only the defined bits are
  // stored, the others read as zero.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sense_q    <= `EIV_RST_SENSE;
      ext_en_q   <= 1'b0;
      grp1_en_q  <= 1'b0;
      grp0_en_q  <= 1'b0;
      tmask_lo_q <= `EIV_RST_BYTE;
      tmask_hi_q <= `EIV_RST_NIBBLE;
    end else if (bus.wr) begin
      case (bus.addr)
        `EIV_OFS_SENSE: begin
          sense_q <= bus.wdata[`EIV_SENSE_HI:`EIV_SENSE_LO];
        end
        `EIV_OFS_MASK: begin
          ext_en_q  <= bus.wdata[`EIV_MASK_EXT];
          grp1_en_q <= bus.wdata[`EIV_MASK_GRP1];
          grp0_en_q <= bus.wdata[`EIV_MASK_GRP0];
        end
        `EIV_OFS_TMASK_LO: begin
          tmask_lo_q <= bus.wdata;
        end
        `EIV_OFS_TMASK_HI: begin
          tmask_hi_q <= bus.wdata[`EIV_TMASK_HI_W-1:0];
        end
        default: begin
          sense_q <= sense_q;
        end
      endcase
    end
  end

  // ======================================================================
  // Pending requests
  // Each slot is indexed by its vector number; slot zero is the reset
  // vector and never requests. All sources need the global enable.
  always_comb begin
    pending = '0;
    pending[`EIV_VEC_EXT] = global_irq_enable_in & ext_en_q &
                            (level_active | ext_flag_q);
    pending[`EIV_VEC_GRP0] = global_irq_enable_in & grp0_en_q &
                             grp0_flag_q;
    pending[`EIV_VEC_GRP1] = global_irq_enable_in & grp1_en_q &
                             grp1_flag_q;
    for (int i = 0; i < `EIV_NUM_PER; i++) begin
      pending[int'(`EIV_VEC_FIRST_PER) + i] =
        global_irq_enable_in & periph_irq_in[i];
    end
  end

  // Lowest pending vector number wins; the loop runs downward so that the
  // last assignment made is the lowest slot.
  always_comb begin
    irq_d.req    = 1'b0;
    irq_d.vector = `EIV_RST_VEC;
    for (int i = `EIV_NUM_VEC - 1; i > 0; i--) begin
      if (pending[i]) begin
        irq_d.req    = 1'b1;
        irq_d.vector = 5'(i);
      end
    end
  end

  // ======================================================================
  // Core-facing outputs
  // The presented request is dropped for one cycle after an acknowledge so
  // the cleared flag is not offered a second time.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_req_out    <= 1'b0;
      irq_vector_out <= `EIV_RST_VEC;
    end else if (irq_ack_in && irq_req_out) begin
      irq_req_out    <= 1'b0;
      irq_vector_out <= `EIV_RST_VEC;
    end else begin
      irq_req_out    <= irq_d.req;
      irq_vector_out <= irq_d.vector;
    end
  end

  // Reset vector is a constant word address.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reset_vector_out <= `EIV_VEC_RESET;
    end else begin
      reset_vector_out <= `EIV_VEC_RESET;
    end
  end

  // Wake request: low level or a masked toggle of an enabled group, with
  // no need of the I/O clock or the global enable.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= (ext_en_q & level_active) |
                  (grp0_en_q & (grp0_event | grp0_flag_q)) |
                  (grp1_en_q & (grp1_event | grp1_flag_q));
    end
  end

  // ======================================================================
  // Register read
  // Read data stand in the cycle after the strobe only; unmapped offsets
  // and idle cycles return zero.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= `EIV_RST_BYTE;
    end else begin
      reg_rdata_out <= `EIV_RST_BYTE;
      if (bus.rd) begin
        case (bus.addr)
          `EIV_OFS_SENSE: begin
            reg_rdata_out[`EIV_SENSE_HI:`EIV_SENSE_LO] <= sense_q;
          end
          `EIV_OFS_MASK: begin
            reg_rdata_out[`EIV_MASK_EXT]  <= ext_en_q;
            reg_rdata_out[`EIV_MASK_GRP1] <= grp1_en_q;
            reg_rdata_out[`EIV_MASK_GRP0] <= grp0_en_q;
          end
          `EIV_OFS_FLAG: begin
            reg_rdata_out[`EIV_FLAG_EXT]  <= ext_flag_q;
            reg_rdata_out[`EIV_FLAG_GRP1] <= grp1_flag_q;
            reg_rdata_out[`EIV_FLAG_GRP0] <= grp0_flag_q;
          end
          `EIV_OFS_TMASK_LO: begin
            reg_rdata_out <= tmask_lo_q;
          end
          `EIV_OFS_TMASK_HI: begin
            reg_rdata_out[`EIV_TMASK_HI_W-1:0] <= tmask_hi_q;
          end
          `EIV_OFS_STATUS: begin
            reg_rdata_out[`EIV_STAT_PIN]         <= ext_pin;
            reg_rdata_out[`EIV_STAT_REQ]         <= irq_req_out;
            reg_rdata_out[`EIV_STAT_VEC_HI:0]    <= irq_vector_out;
          end
          default: begin
            reg_rdata_out <= `EIV_RST_BYTE;
          end
        endcase
      end
    end
  end

endmodule

// >>> verif/eiv_core_model.sv
// Purpose: Processor core model that enters vectored requests.
// Assumes: Acknowledge is a one-cycle pulse while the request stands.
// Notes:   The bench turns service on and sets the answer delay.
`timescale 1ns/1ps

module eiv_core_model
  import eiv_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Request from the block and service control from the bench.
  input  wire eiv_irq_type irq_in,
  input  wire logic        serve_in,
  input  wire logic [3:0]  delay_in,
  // Acknowledge and a record of the last vector entered.
  output logic             ack_out,
  output logic [4:0]       taken_out,
  output logic [7:0]       count_out
);
  logic [3:0] wait_q;

  // ====================================================================
  // Service
  // Acknowledge only a standing request, after the chosen delay.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_out   <= 1'b0;
      taken_out <= 5'h00;
      count_out <= 8'h00;
      wait_q    <= 4'h0;
    end else if (ack_out) begin
      ack_out   <= 1'b0;
      taken_out <= irq_in.vector;
      count_out <= count_out + 8'h01;
      wait_q    <= 4'h0;
    end else if (irq_in.req && serve_in && wait_q >= delay_in) begin
      ack_out <= 1'b1;
    end else if (irq_in.req && serve_in) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

// >>> verif/eiv_monitor.sv
// Purpose: Port checks of the external interrupt and vector logic.
// Assumes: One clock domain, bound to eiv_top.
// Notes:   Sees only the ports of the top module.
`timescale 1ns/1ps

module eiv_monitor (
  // Clock and reset.
  input wire logic        clk_in,
  input wire logic        srst_in,
  // Register port and core side.
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        global_irq_enable_in,
  input wire logic [25:0] periph_irq_in,
  input wire logic        irq_req_out,
  input wire logic [4:0]  irq_vector_out,
  input wire logic        irq_ack_in,
  input wire logic [4:0]  reset_vector_out
);
  // ====================================================================
  // Sequences
  // All checks share the one clock and pause while reset is high.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_glob_off;
    !global_irq_enable_in [*2];
  endsequence
  sequence s_dog_held;
    (periph_irq_in[0] && global_irq_enable_in && !irq_ack_in) [*3];
  endsequence

  // ====================================================================
  // Properties
  // The first three check outputs alone; the rest tie an output to its cause at the inputs.
  property p_reset_vec; reset_vector_out == 5'h00; endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector not zero");
  property p_vec_range;
    irq_req_out |-> irq_vector_out inside {[5'h01:5'h1D]};
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("request vector out of range");
  property p_idle_vec; !irq_req_out |-> irq_vector_out == 5'h00; endproperty
  a_idle_vec: assert property (p_idle_vec)
    else $error("vector shown without request");
  property p_ack_drop; irq_req_out && irq_ack_in |=> !irq_req_out; endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request kept after service entry");
  property p_glob_off; s_glob_off |=> !irq_req_out; endproperty
  a_glob_off: assert property (p_glob_off)
    else $error("request with global enable low");
  property p_rose_glob;
    $rose(irq_req_out) |-> $past(global_irq_enable_in);
  endproperty
  a_rose_glob: assert property (p_rose_glob)
    else $error("request rose without global enable");
  property p_dog_first;
    s_dog_held |-> irq_req_out && irq_vector_out <= 5'h04;
  endproperty
  a_dog_first: assert property (p_dog_first)
    else $error("higher vector shown over watchdog");
  property p_rdata_idle;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule

bind eiv_top eiv_monitor i_mon (
  .clk_in(clk_in), .srst_in(srst_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .global_irq_enable_in(global_irq_enable_in),
  .periph_irq_in(periph_irq_in), .irq_req_out(irq_req_out),
  .irq_vector_out(irq_vector_out), .irq_ack_in(irq_ack_in),
  .reset_vector_out(reset_vector_out)
);

// >>> verif/tb_top.sv
// Purpose: Self-checking bench of the external interrupt and vector logic.
// Assumes: Read data stands one cycle after the read strobe.
// Notes:   Ten-cycle waits cover the pad filter latency.
`timescale 1ns/1ps
`include "eiv_map.svh"

module tb_top
  import eiv_pkg::*;
;
  // ====================================================================
  // Signals
  logic        clk = 1'b0;
  logic        srst, ext_pin, glob, io_run, req, ack, wake, serve;
  eiv_bus_type bus;
  eiv_irq_type irq;
  logic [7:0]  rdata, tcnt;
  logic [11:0] tog;
  logic [25:0] per;
  logic [4:0]  vec, rvec, taken;
  logic [3:0]  dly;
  int          fails = 0;
  int          checked = 0;
  logic [5:0]  acc_ofs [5] = '{`EIV_OFS_SENSE, `EIV_OFS_MASK,
    `EIV_OFS_TMASK_LO, `EIV_OFS_TMASK_HI, `EIV_OFS_STATUS};
  logic [7:0]  acc_exp [5] = '{8'h03, 8'h70, 8'hFF, 8'h0F, 8'h80};

  // 25 MHz clock.
  always #20 clk = ~clk;

  // Block under test and the core model facing it.
  eiv_top i_dut (
    .clk_in(clk), .srst_in(srst), .reg_addr_in(bus.addr),
    .reg_wdata_in(bus.wdata), .reg_wr_in(bus.wr), .reg_rd_in(bus.rd),
    .reg_rdata_out(rdata), .ext_irq_pin_in(ext_pin),
    .pin_toggle_input_in(tog), .global_irq_enable_in(glob),
    .io_clk_run_in(io_run), .periph_irq_in(per), .irq_req_out(req),
    .irq_vector_out(vec), .irq_ack_in(ack), .reset_vector_out(rvec),
    .wake_out(wake)
  );
  assign irq = '{req: req, vector: vec};
  eiv_core_model i_core (
    .clk_in(clk), .srst_in(srst), .irq_in(irq), .serve_in(serve),
    .delay_in(dly), .ack_out(ack), .taken_out(taken), .count_out(tcnt)
  );

  // ====================================================================
  // Tasks
  // Compare one byte and count it.
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle.
  task automatic rd(input string n, input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  // Drive the pads, then let the filter settle.
  task automatic pads(input logic e, input logic [11:0] t);
    @(posedge clk);
    ext_pin <= e;
    tog <= t;
    repeat (10) @(posedge clk);
  endtask
  // Wait, bounded, for the core model to enter one more vector.
  task automatic take(input logic [4:0] e);
    logic [7:0] c0;
    c0 = tcnt;
    for (int k = 0; tcnt === c0; k++) begin
      if (k == 60) begin
        chk("service_wait", 8'h00, 8'h01);
        complete_run();
      end
      @(posedge clk);
    end
    #1;
    chk("taken_vector", {3'h0, e}, {3'h0, taken});
  endtask
  // Verdict and end of run.
  task automatic complete_run;
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ====================================================================
  // Scenarios
  initial begin
    srst = 1'b1;
    bus = '0;
    ext_pin = 1'b1;
    tog = 12'h000;
    {glob, serve, io_run} = 3'b001;
    per = '0;
    dly = 4'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rd("reset", acc_ofs[i], 8'h00);
    rd("reset_flag", `EIV_OFS_FLAG, 8'h00);
    rd("unmapped", 6'h00, 8'h00);
    chk("reset_vector", 8'h00, {3'h0, rvec});
    for (int i = 0; i < 5; i++) begin
      wr(acc_ofs[i], 8'hFF);
      rd("access", acc_ofs[i], acc_exp[i]);
      wr(acc_ofs[i], 8'h00);
    end
    // Every edge sense mode, with flag clearing by writing a one.
    glob <= 1'b1;
    wr(`EIV_OFS_MASK, 8'h40);
    for (int m = 1; m < 4; m++) begin
      wr(`EIV_OFS_SENSE, 8'(m));
      wr(`EIV_OFS_FLAG, 8'hFF);
      pads(1'b0, tog);
      rd("fall_flag", `EIV_OFS_FLAG, (m == 3) ? 8'h00 : 8'h40);
      pads(1'b1, tog);
      rd("edge_status", `EIV_OFS_STATUS, 8'hA1);
      wr(`EIV_OFS_FLAG, 8'h40);
      rd("flag_clear", `EIV_OFS_FLAG, 8'h00);
    end
    // Short pulse held off by the global enable, then serviced.
    wr(`EIV_OFS_SENSE, 8'h02);
    glob <= 1'b0;
    @(posedge clk);
    ext_pin <= 1'b0;
    repeat (3) @(posedge clk);
    pads(1'b1, tog);
    rd("pulse_flag", `EIV_OFS_FLAG, 8'h40);
    rd("gated_status", `EIV_OFS_STATUS, 8'h80);
    @(posedge clk);
    glob <= 1'b1;
    serve <= 1'b1;
    take(5'h01);
    rd("served_flag", `EIV_OFS_FLAG, 8'h00);
    // Level sensing keeps requesting while the pin is low.
    wr(`EIV_OFS_SENSE, 8'h00);
    pads(1'b0, tog);
    rd("level_flag", `EIV_OFS_FLAG, 8'h00);
    take(5'h01);
    take(5'h01);
    @(posedge clk);
    serve <= 1'b0;
    pads(1'b1, tog);
    rd("level_gone", `EIV_OFS_STATUS, 8'h80);
    // Halted I/O clock: edges not flagged while halted, low level still wakes.
    wr(`EIV_OFS_SENSE, 8'h02);
    io_run <= 1'b0;
    pads(1'b0, tog);
    rd("sleep_edge", `EIV_OFS_FLAG, 8'h00);
    wr(`EIV_OFS_SENSE, 8'h00);
    pads(1'b0, tog);
    #1;
    chk("level_wake", 8'h01, {7'h0, wake});
    pads(1'b1, tog);
    io_run <= 1'b1;
    rd("no_level_irq", `EIV_OFS_STATUS, 8'h80);
    // Toggle groups, masks, priority and service order.
    wr(`EIV_OFS_TMASK_LO, 8'h08);
    wr(`EIV_OFS_TMASK_HI, 8'h02);
    wr(`EIV_OFS_MASK, 8'h30);
    pads(1'b1, 12'h010);
    rd("unmasked", `EIV_OFS_FLAG, 8'h00);
    pads(1'b1, 12'h018);
    io_run <= 1'b0;
    rd("group0", `EIV_OFS_FLAG, 8'h01);
    pads(1'b1, 12'h218);
    #1;
    chk("toggle_wake", 8'h01, {7'h0, wake});
    rd("group1", `EIV_OFS_FLAG, 8'h03);
    rd("pending", `EIV_OFS_STATUS, 8'hA2);
    @(posedge clk);
    io_run <= 1'b1;
    serve <= 1'b1;
    dly <= 4'h3;
    take(5'h02);
    take(5'h03);
    @(posedge clk);
    serve <= 1'b0;
    rd("served", `EIV_OFS_FLAG, 8'h00);
    // Peripheral sources map above the pin sources.
    @(posedge clk);
    per <= 26'h2000000;
    repeat (10) @(posedge clk);
    rd("two_wire", `EIV_OFS_STATUS, 8'hBD);
    @(posedge clk);
    per <= 26'h2000001;
    repeat (10) @(posedge clk);
    rd("watchdog", `EIV_OFS_STATUS, 8'hA4);
    complete_run();
  end
endmodule
